// [verilog/mrx_pkg.sv]
/*
 * Constants and carrier types for the receive acceptance and transmit
 * event register block.
 * Assumes one 100 MHz clock and a 10 Mb/s line (one bit time = 10 cycles).
 */
`default_nettype none

package mrx_pkg;

	// ----------------------------------------------------------------
	// register map (index; byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int APB_AW = 18;
	localparam logic [15:0] IDX_RX_CTL = 16'h0104;
	localparam logic [15:0] IDX_TX_EN = 16'h0106;
	localparam logic [15:0] IDX_TX_EVT = 16'h0128;
	localparam logic [15:0] IDX_STA0 = 16'h0158;
	localparam logic [15:0] IDX_STA1 = 16'h015a;
	localparam logic [15:0] IDX_STA2 = 16'h015c;

	// ----------------------------------------------------------------
	// identifiers, reset values, writable and read-clear bits
	// ----------------------------------------------------------------
	localparam logic [5:0] ID_RX_CTL = 6'h05;
	localparam logic [5:0] ID_TX_EN = 6'h07;
	localparam logic [5:0] ID_TX_EVT = 6'h08;
	localparam logic [15:0] RST_RX_CTL = 16'h0005;
	localparam logic [15:0] RST_TX_EN = 16'h0007;
	localparam logic [15:0] RST_TX_EVT = 16'h0008;
	localparam logic [15:0] RX_CTL_WMASK = 16'h7fc0;
	localparam logic [15:0] TX_EN_WMASK = 16'h8fc0;
	localparam logic [15:0] EVT_FLAG_MASK = 16'h87c0;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_UNI_HASH = 6;
	localparam int B_ALL = 7;
	localparam int B_GOOD = 8;
	localparam int B_GRP_HASH = 9;
	localparam int B_STATION = 10;
	localparam int B_BCAST = 11;
	localparam int B_BAD_CHECK = 12;
	localparam int B_SHORT = 13;
	localparam int B_LONG = 14;
	localparam int E_CARRIER = 6;
	localparam int E_HEARTBEAT = 7;
	localparam int E_OK = 8;
	localparam int E_LATE = 9;
	localparam int E_JABBER = 10;
	localparam int E_CNT_LSB = 11;
	localparam int E_CNT_MSB = 14;
	localparam int E_EXCESS = 15;

	// ----------------------------------------------------------------
	// frame lengths and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] LEN_MIN = 16'd64;
	localparam logic [15:0] LEN_MAX = 16'd1518;
	localparam logic [15:0] LEN_TINY = 16'd8;
	localparam logic [4:0] COLL_LIMIT = 5'd16;
	localparam int CLK_NS = 10;
	localparam int BIT_NS = 100;
	localparam int PREAMBLE_BITS = 64;
	localparam int SQE_BITS = 64;
	localparam int SLOT_BITS = 512;
	localparam int JABBER_NS = 26000000;
	localparam int TMR_W = 22;
	localparam logic [TMR_W-1:0] PRE_CYC =
		TMR_W'(PREAMBLE_BITS * BIT_NS / CLK_NS);
	localparam logic [TMR_W-1:0] SQE_CYC = TMR_W'(SQE_BITS * BIT_NS / CLK_NS);
	localparam int LATE_CYC = (SLOT_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int JABBER_CYC = (JABBER_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MRX_IDLE, MRX_SEND, MRX_SQE} mrx_tx_st_t;

	typedef struct packed {
		logic done;
		logic [47:0] dest;
		logic [15:0] len;
		logic crc_bad;
		logic hash_hit;
	} mrx_rx_frame_t;

	typedef struct packed {
		logic accept;
		logic discard;
		logic [15:0] store_len;
	} mrx_rx_verdict_t;

	typedef struct packed {
		logic pkt_start;
		logic att_start;
		logic att_end;
		logic on_aui;
	} mrx_tx_ctl_t;

	typedef struct packed {
		logic kill;
		logic bad_crc;
		logic give_up;
	} mrx_tx_act_t;

	typedef struct packed {
		logic [15:6] rx_ctl;
		logic [15:6] tx_en;
		logic [15:6] evt;
		logic [15:6] cap_evt;
		logic [47:0] sta;
		mrx_tx_st_t st;
		logic aui;
		logic [TMR_W-1:0] tmr;
		logic [4:0] coll;
		logic [2:0] car_s;
		logic car_f;
		logic [2:0] col_s;
		logic col_f;
		logic col_prev;
		logic irq;
		logic err;
		logic [31:0] prdata;
		mrx_rx_verdict_t verdict;
		mrx_tx_act_t act;
	} mrx_state_t;

endpackage : mrx_pkg

`default_nettype wire

// [verilog/mrx_regs.sv]
/*
 * Receive frame acceptance control and transmit event reporting, with the
 * registers on an APB slave.
 * Assumes the receive path hands over each finished frame's destination,
 * length, check result and hash verdict in one cycle, and the transmitter
 * pulses packet start, attempt start and attempt end on this clock.
 * Carrier sense and the collision/heartbeat line are asynchronous pins.
 */
// Design decision made here: the APB register port.
`default_nettype none

module mrx_regs #(
	parameter int LATE_CYCLES = mrx_pkg::LATE_CYC,
	parameter int JABBER_CYCLES = mrx_pkg::JABBER_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [mrx_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// receive frame verdict
	input wire mrx_pkg::mrx_rx_frame_t RX_FRAME,
	output mrx_pkg::mrx_rx_verdict_t RX_VERDICT,
	// transmit supervision
	input wire mrx_pkg::mrx_tx_ctl_t TX_CTL,
	input wire logic CARRIER_SENSE,
	input wire logic COLLISION_IN,
	output mrx_pkg::mrx_tx_act_t TX_ACT,
	// host interrupt
	output logic IRQ
);
	import mrx_pkg::*;

	// ----------------------------------------------------------------
	// state and constants
	// ----------------------------------------------------------------
	localparam logic [TMR_W-1:0] LATE_T = TMR_W'(LATE_CYCLES);
	localparam logic [TMR_W-1:0] JAB_T = TMR_W'(JABBER_CYCLES);
	localparam mrx_state_t RST_STATE = '{
		rx_ctl: RST_RX_CTL[15:6],
		tx_en: RST_TX_EN[15:6],
		evt: RST_TX_EVT[15:6],
		st: MRX_IDLE,
		default: '0
	};

	mrx_state_t q;
	mrx_state_t d;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge16

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic setup;
		logic access;
		logic [15:0] idx;
		logic hit;
		logic [15:0] rd;
		logic [15:0] set;
		logic [15:0] clr;
		logic cnt_wr;
		logic [3:0] cnt_val;
		logic end_pkt;
		logic coll_ev;
		logic [4:0] coll_nx;
		logic [15:0] c;
		logic grp;
		logic pass;
		logic short_f;
		logic long_f;
		logic tiny_f;
		logic keep;
		logic [15:0] ev_full;

		d = q;
		rd = '0;
		ev_full = '0;
		setup = PSEL & ~PENABLE;
		access = PSEL & PENABLE;
		idx = PADDR[17:2];
		set = '0;
		clr = '0;
		cnt_wr = 1'b0;
		cnt_val = '0;
		end_pkt = 1'b0;
		coll_nx = q.coll;
		d.act = '0;
		d.verdict.accept = 1'b0;
		d.verdict.discard = 1'b0;

		// pin synchronisers: a change counts once stages 2 and 3 agree
		d.car_s = {q.car_s[1:0], CARRIER_SENSE};
		d.col_s = {q.col_s[1:0], COLLISION_IN};
		if (q.car_s[1] == q.car_s[2]) begin
			d.car_f = q.car_s[2];
		end
		if (q.col_s[1] == q.col_s[2]) begin
			d.col_f = q.col_s[2];
		end
		d.col_prev = q.col_f;
		coll_ev = q.col_f & ~q.col_prev;

		// ------------------------------------------------------------
		// register read capture in the setup cycle
		// ------------------------------------------------------------
		hit = (PADDR[1:0] == 2'b00);
		case (idx)
			IDX_RX_CTL: rd = {q.rx_ctl, ID_RX_CTL};
			IDX_TX_EN: rd = {q.tx_en, ID_TX_EN};
			IDX_TX_EVT: rd = {q.evt, ID_TX_EVT};
			IDX_STA0: rd = q.sta[15:0];
			IDX_STA1: rd = q.sta[31:16];
			IDX_STA2: rd = q.sta[47:32];
			default: begin
				rd = '0;
				hit = 1'b0;
			end
		endcase
		if (setup) begin
			d.err = ~hit;
			// a refused access returns zero, even for a mapped index
			d.prdata = hit ? {16'h0000, rd} : 32'h0000_0000;
			// only what was read is cleared; later events survive
			d.cap_evt = (idx == IDX_TX_EVT && !PWRITE) ? q.evt : '0;
		end

		// ------------------------------------------------------------
		// writes and read-clear in the access cycle
		// ------------------------------------------------------------
		if (access && !q.err && PWRITE) begin
			ev_full = merge16({q.rx_ctl, 6'h00}, PWDATA[15:0], PSTRB[1:0]);
			if (idx == IDX_RX_CTL) begin
				d.rx_ctl = ev_full[15:6] & RX_CTL_WMASK[15:6];
			end
			ev_full = merge16({q.tx_en, 6'h00}, PWDATA[15:0], PSTRB[1:0]);
			if (idx == IDX_TX_EN) begin
				d.tx_en = ev_full[15:6] & TX_EN_WMASK[15:6];
			end
			if (idx == IDX_STA0) begin
				d.sta[15:0] = merge16(q.sta[15:0], PWDATA[15:0], PSTRB[1:0]);
			end
			if (idx == IDX_STA1) begin
				d.sta[31:16] = merge16(q.sta[31:16], PWDATA[15:0], PSTRB[1:0]);
			end
			if (idx == IDX_STA2) begin
				d.sta[47:32] = merge16(q.sta[47:32], PWDATA[15:0], PSTRB[1:0]);
			end
		end
		if (access && !q.err && !PWRITE && idx == IDX_TX_EVT) begin
			clr = {q.cap_evt, 6'h00};
		end

		// ------------------------------------------------------------
		// receive acceptance
		// ------------------------------------------------------------
		c = {q.rx_ctl, 6'h00};
		grp = RX_FRAME.dest[0];
		pass = (c[B_UNI_HASH] & ~grp & RX_FRAME.hash_hit)
			| c[B_ALL]
			| (c[B_GRP_HASH] & grp & RX_FRAME.hash_hit)
			| (c[B_STATION] & (RX_FRAME.dest == q.sta))
			| (c[B_BCAST] & (&RX_FRAME.dest));
		short_f = RX_FRAME.len < LEN_MIN;
		long_f = RX_FRAME.len > LEN_MAX;
		tiny_f = RX_FRAME.len < LEN_TINY;
		keep = (~RX_FRAME.crc_bad | c[B_BAD_CHECK])
			& (~short_f | c[B_SHORT])
			& (~long_f | c[B_LONG])
			& (RX_FRAME.crc_bad | short_f | long_f | c[B_GOOD]);
		if (RX_FRAME.done) begin
			d.verdict.accept = pass & keep & ~tiny_f;
			d.verdict.discard = ~(pass & keep & ~tiny_f);
			d.verdict.store_len = long_f ? LEN_MAX : RX_FRAME.len;
		end

		// ------------------------------------------------------------
		// transmit supervision
		// ------------------------------------------------------------
		if (TX_CTL.pkt_start) begin
			coll_nx = '0;
		end
		case (q.st)
			MRX_IDLE: begin
				if (TX_CTL.att_start) begin
					d.st = MRX_SEND;
					d.tmr = '0;
					d.aui = TX_CTL.on_aui;
				end
			end
			MRX_SEND: begin
				d.tmr = q.tmr + 1'b1;
				if (q.aui && q.tmr == PRE_CYC && !q.car_f) begin
					set[E_CARRIER] = 1'b1;
				end
				if (q.tmr >= JAB_T) begin
					d.act.kill = 1'b1;
					set[E_JABBER] = 1'b1;
					end_pkt = 1'b1;
					d.st = MRX_IDLE;
				end else if (coll_ev && q.tmr > LATE_T) begin
					d.act.kill = 1'b1;
					d.act.bad_crc = 1'b1;
					set[E_LATE] = 1'b1;
					end_pkt = 1'b1;
					d.st = MRX_IDLE;
				end else if (coll_ev) begin
					coll_nx = q.coll + 5'd1;
					d.st = MRX_IDLE;
					if (coll_nx == COLL_LIMIT) begin
						d.act.give_up = 1'b1;
						set[E_EXCESS] = 1'b1;
						end_pkt = 1'b1;
					end
				end else if (TX_CTL.att_end) begin
					set[E_OK] = 1'b1;
					end_pkt = 1'b1;
					d.st = q.aui ? MRX_SQE : MRX_IDLE;
					d.tmr = '0;
				end
			end
			MRX_SQE: begin
				d.tmr = q.tmr + 1'b1;
				if (coll_ev) begin
					d.st = MRX_IDLE;
				end else if (q.tmr == SQE_CYC - 1'b1) begin
					set[E_HEARTBEAT] = 1'b1;
					d.st = MRX_IDLE;
				end
			end
			default: d.st = MRX_IDLE;
		endcase
		d.coll = coll_nx;
		if (end_pkt) begin
			cnt_wr = 1'b1;
			cnt_val = coll_nx[3:0];
		end

		// ------------------------------------------------------------
		// event register and interrupt; a set wins over the read clear
		// ------------------------------------------------------------
		ev_full = ({q.evt, 6'h00} & ~(clr & EVT_FLAG_MASK)) | set;
		if (cnt_wr) begin
			ev_full[E_CNT_MSB:E_CNT_LSB] = cnt_val;
		end else if (clr[E_CNT_MSB:E_CNT_LSB] == q.evt[E_CNT_MSB:E_CNT_LSB]) begin
			ev_full[E_CNT_MSB:E_CNT_LSB] = '0;
		end
		d.evt = ev_full[15:6];
		d.irq = (q.irq & ~(|clr | (clr == '0 && access && !q.err
			&& !PWRITE && idx == IDX_TX_EVT)))
			| (|(set & {q.tx_en, 6'h00}))
			| (end_pkt && coll_nx != '0 && q.tx_en[E_CNT_LSB]);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign PREADY = PSEL & PENABLE;
	assign PSLVERR = PSEL & PENABLE & q.err;
	assign PRDATA = q.prdata;
	assign RX_VERDICT = q.verdict;
	assign TX_ACT = q.act;
	assign IRQ = q.irq;

endmodule : mrx_regs

`default_nettype wire

// [dv/mrx_regs_props.sv]
/*
 * Port-level checker for the acceptance and transmit event register block.
 * Assumes one clock, active-low async reset, zero-wait APB.
 */
`default_nettype none

module mrx_regs_props (
	// clock, reset, apb
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [mrx_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// receive, transmit, interrupt
	input wire mrx_pkg::mrx_rx_frame_t RX_FRAME,
	input wire mrx_pkg::mrx_rx_verdict_t RX_VERDICT,
	input wire mrx_pkg::mrx_tx_act_t TX_ACT,
	input wire logic IRQ
);
	import mrx_pkg::*;

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence s_evt_read;
		PSEL && PENABLE && !PWRITE && PADDR == {IDX_TX_EVT, 2'b00};
	endsequence

	a_ready_now: assert property (PSEL && PENABLE |-> PREADY)
		else $error("access cycle without ready");
	a_evt_ident: assert property (s_evt_read |-> PRDATA[5:0] == ID_TX_EVT)
		else $error("event identifier wrong");
	a_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0)
		else $error("upper read bits set");
	a_read_drops_irq: assert property (s_evt_read |=> !IRQ)
		else $error("irq held after event read");
	a_one_verdict: assert property (RX_FRAME.done |=>
		RX_VERDICT.accept ^ RX_VERDICT.discard) else $error("no verdict");
	a_no_stray: assert property (RX_VERDICT.accept || RX_VERDICT.discard
		|-> $past(RX_FRAME.done)) else $error("verdict without frame");
	a_tiny_dropped: assert property (RX_FRAME.done && RX_FRAME.len < LEN_TINY
		|=> RX_VERDICT.discard) else $error("tiny frame kept");
	a_store_clip: assert property (RX_FRAME.done && RX_FRAME.len > LEN_MAX
		|=> RX_VERDICT.store_len == LEN_MAX) else $error("long not clipped");
	a_store_len: assert property (RX_FRAME.done && RX_FRAME.len <= LEN_MAX
		|=> RX_VERDICT.store_len == $past(RX_FRAME.len))
		else $error("stored length wrong");
	a_late_badcrc: assert property (TX_ACT.bad_crc |-> TX_ACT.kill)
		else $error("bad check without stop");
	a_err_no_data: assert property (PSLVERR |-> PRDATA == 32'h0)
		else $error("error with data");
endmodule : mrx_regs_props

bind mrx_regs mrx_regs_props mrx_regs_props_inst (.CLK, .RESETN, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .RX_FRAME,
	.RX_VERDICT, .TX_ACT, .IRQ);

`default_nettype wire

// [dv/mrx_tx_partner.sv]
/*
 * Transmitter and line model: attempt pulses, carrier and collision pins.
 * Assumes the caller runs one attempt at a time.
 */
`default_nettype none

module mrx_tx_partner (
	input wire logic CLK,
	output var mrx_pkg::mrx_tx_ctl_t TX_CTL,
	output var logic CARRIER_SENSE,
	output var logic COLLISION_IN
);
	import mrx_pkg::*;

	// ------------------------------------------------------------
	// one attempt; coll_at or end_at of 0 means never
	// ------------------------------------------------------------
	initial begin
		TX_CTL = '0;
		CARRIER_SENSE = 1'b0;
		COLLISION_IN = 1'b0;
	end

	task automatic attempt(input logic aui, input logic car, input int coll_at,
			input int end_at, input logic first);
		@(posedge CLK);
		TX_CTL.pkt_start <= first;
		TX_CTL.on_aui <= aui;
		@(posedge CLK);
		TX_CTL.pkt_start <= 1'b0;
		TX_CTL.att_start <= 1'b1;
		CARRIER_SENSE <= car;
		@(posedge CLK);
		TX_CTL.att_start <= 1'b0;
		for (int i = 1; i < 3000; i++) begin
			@(posedge CLK);
			// held 8 cycles so the 3-flop filter sees it
			if (i == coll_at) COLLISION_IN <= 1'b1;
			if (coll_at != 0 && i == coll_at + 8) begin
				COLLISION_IN <= 1'b0;
				break;
			end
			if (i == end_at) begin
				TX_CTL.att_end <= 1'b1;
				break;
			end
		end
		@(posedge CLK);
		TX_CTL.att_end <= 1'b0;
		// carrier is idle low outside a frame
		CARRIER_SENSE <= 1'b0;
	endtask : attempt
endmodule : mrx_tx_partner

`default_nettype wire

// [dv/test_mrx_regs.sv]
/*
 * Self-checking bench: receive acceptance table, then transmit events.
 * Assumes the zero-wait APB slave and shortened late/jabber counts.
 */
`default_nettype none

module test_mrx_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import mrx_pkg::*;

	// ------------------------------------------------------------
	// signals and cases
	// ------------------------------------------------------------
	localparam logic [17:0] CTL = {IDX_RX_CTL, 2'b00};
	localparam logic [17:0] EN = {IDX_TX_EN, 2'b00};
	localparam logic [17:0] EVT = {IDX_TX_EVT, 2'b00};
	localparam logic [47:0] STA = 48'h665544332211;
	localparam logic [47:0] UNI = 48'h000012345678;
	localparam logic [47:0] GRP = 48'h000012345679;
	typedef struct packed {
		logic [15:0] ctl;
		logic [47:0] dest;
		logic [15:0] len;
		logic [2:0] bha;
	} mrx_row_t;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, irq, rdy, err, e;
	logic [17:0] pa = '0;
	logic [31:0] pwd = '0, prd, rd;
	mrx_rx_frame_t rx = '0;
	mrx_rx_verdict_t vd;
	mrx_tx_ctl_t txc;
	mrx_tx_act_t act;
	logic carrier_sense, col;
	int n_fail = 0, checks = 0;
	// bha: bad check, hash hit, expected accept
	mrx_row_t rows [14] = '{
		'{16'h0100, STA, 16'd100, 3'b000},
		'{16'h0180, UNI, 16'd64, 3'b001},
		'{16'h0140, UNI, 16'd100, 3'b011},
		'{16'h0140, GRP, 16'd100, 3'b010},
		'{16'h0300, GRP, 16'd100, 3'b011},
		'{16'h0500, STA, 16'd1518, 3'b001},
		'{16'h0900, 48'hffffffffffff, 16'd100, 3'b001},
		'{16'h0180, UNI, 16'd100, 3'b100},
		'{16'h1180, UNI, 16'd100, 3'b101},
		'{16'h0180, UNI, 16'd63, 3'b000},
		'{16'h2180, UNI, 16'd63, 3'b001},
		'{16'h2180, UNI, 16'd7, 3'b000},
		'{16'h0180, UNI, 16'd1519, 3'b000},
		'{16'h4180, UNI, 16'd1519, 3'b001}};

	mrx_regs #(.LATE_CYCLES(200), .JABBER_CYCLES(2000)) mrx_regs_inst (
		.CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(rdy),
		.PSLVERR(err), .RX_FRAME(rx), .RX_VERDICT(vd), .TX_CTL(txc),
		.CARRIER_SENSE(carrier_sense), .COLLISION_IN(col), .TX_ACT(act), .IRQ(irq));
	mrx_tx_partner mrx_tx_partner_inst (.CLK(clk), .TX_CTL(txc),
		.CARRIER_SENSE(carrier_sense), .COLLISION_IN(col));

	initial forever #5 clk = ~clk;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [17:0] a,
			input logic [15:0] d, output logic [31:0] r, output logic x);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {16'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!rdy && n < 20);
		r = prd;
		x = err;
		psel <= 1'b0;
		pen <= 1'b0;
		if (!rdy) begin
			n_fail++;
			finish_test();
		end
	endtask : apb

	task automatic rdc(input logic [17:0] a, input logic [31:0] x);
		apb(1'b0, a, 16'h0, rd, e);
		chk(rd, x);
	endtask : rdc

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdc(CTL, 32'h0005);
		rdc(EN, 32'h0007);
		rdc(EVT, 32'h0008);
		apb(1'b0, 18'h00004, 16'h0, rd, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, 18'h00560, 16'h2211, rd, e);
		apb(1'b1, 18'h00568, 16'h4433, rd, e);
		apb(1'b1, 18'h00570, 16'h6655, rd, e);
		foreach (rows[i]) begin
			apb(1'b1, CTL, rows[i].ctl, rd, e);
			@(posedge clk);
			rx <= '{1'b1, rows[i].dest, rows[i].len, rows[i].bha[2],
				rows[i].bha[1]};
			@(posedge clk);
			rx.done <= 1'b0;
			#1;
			chk({30'h0, vd.accept, vd.discard},
				{30'h0, rows[i].bha[0], !rows[i].bha[0]});
		end
		rdc(CTL, 32'h4185);
		apb(1'b1, EN, 16'h0000, rd, e);
		// frame outlasts the preamble so the carrier check is reached
		mrx_tx_partner_inst.attempt(1'b1, 1'b0, 0, 700, 1'b1);
		repeat (700) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(EVT, 32'h01c8);
		rdc(EVT, 32'h0008);
		apb(1'b1, EN, 16'h0800, rd, e);
		mrx_tx_partner_inst.attempt(1'b0, 1'b0, 20, 0, 1'b1);
		mrx_tx_partner_inst.attempt(1'b0, 1'b0, 0, 100, 1'b0);
		repeat (10) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rdc(EVT, 32'h0908);
		#1;
		chk({31'h0, irq}, 32'h0);
		for (int k = 0; k < 16; k++)
			mrx_tx_partner_inst.attempt(1'b0, 1'b0, 20, 0, k == 0);
		repeat (10) @(posedge clk);
		rdc(EVT, 32'h8008);
		mrx_tx_partner_inst.attempt(1'b0, 1'b0, 250, 0, 1'b1);
		repeat (10) @(posedge clk);
		apb(1'b0, EVT, 16'h0, rd, e);
		chk(rd & 32'h87ff, 32'h0208);
		mrx_tx_partner_inst.attempt(1'b0, 1'b0, 0, 0, 1'b1);
		rdc(EVT, 32'h0408);
		finish_test();
	end
endmodule : test_mrx_regs

`default_nettype wire
